// File: hw/isp_map.svh
// Purpose: Offsets, field positions and reset values of the serial port
// Assumes: Register index times four is the Wishbone byte address
// Notes:   Field positions count from bit zero of each register
// Function
// - Reset or disable clears start and stop bits
// - Start sets start bit, stop sets stop bit
// - Master pins drive only low, per direction bit
// - Event flag on start and stop in modes B, E, F only, every byte
// - Master usable with slave idle or active
// - Stop raises interrupt when enabled
// - Lost arbitration: slave keeps receiving and acknowledging
// - 7-bit match: flag, then transmit or receive
// - Receive: full or overflow gives overflow, no acknowledge
// - Transmit holds clock while empty and unreleased
// - 10-bit high byte write: update flag, hold
// - Low byte match: remember, acknowledge, hold, receive
// - Sample on rise, compare on eighth fall
// - Buffer read clears full; overflow stays set
// - Master no-acknowledge ends transmit, back to wait
// - 10-bit first byte is 11110, A9, A8
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH
// ==========================================================
// Register indices
`define ISP_IDX_INT_CONTROL    8'h0B
`define ISP_IDX_FLAGS_ONE      8'h0C
`define ISP_IDX_DATA_BUFFER    8'h13
`define ISP_IDX_SERIAL_CONTROL 8'h14
`define ISP_IDX_PORT_C_DIR     8'h87
`define ISP_IDX_ENABLES_ONE    8'h8C
`define ISP_IDX_SLAVE_ADDRESS  8'h93
`define ISP_IDX_SERIAL_STATUS  8'h94
// ==========================================================
// Reset values and field positions
`define ISP_RST_PORT_C_DIR     8'h3F
`define ISP_RST_ZERO           8'h00
`define ISP_B_GLOBAL_GATE      7
`define ISP_B_PERIPH_GATE      6
`define ISP_B_EVENT            3
`define ISP_B_COLLISION        7
`define ISP_B_OVERFLOW         6
`define ISP_B_PORT_ON          5
`define ISP_B_RELEASE          4
`define ISP_B_SDA_DIR          4
`define ISP_B_SCL_DIR          3
`define ISP_MODE_MASTER_IDLE   4'hB
`define ISP_TEN_BIT_TAG        5'h1E
`define ISP_BITS_PER_BYTE      4'h8
`endif

// File: hw/isp_pkg.sv
// Purpose: Types shared by the serial port design
// Assumes: Nothing beyond the map header
// Notes:   Slave states follow a Gray sequence along the byte path
package isp_pkg;
  typedef enum logic [2:0] {
    S_WAIT = 3'h0,
    S_RXB  = 3'h1,
    S_ACK  = 3'h3,
    S_HOLD = 3'h2,
    S_TXB  = 3'h6,
    S_TACK = 3'h7
  } isp_state_e;
  typedef enum logic [1:0] {
    PH_A1  = 2'h0,
    PH_A2  = 2'h1,
    PH_DAT = 2'h3
  } isp_phase_e;
endpackage

// File: hw/isp_sync.sv
// Purpose: Two-stage synchroniser for the bus pins
// Assumes: Pins idle high
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module isp_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i, // System clock
  input  wire logic         rst_i, // Sync reset, active high
  input  wire logic [W-1:0] d_i,   // Asynchronous pins
  output logic      [W-1:0] q_o    // Synchronised pins
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '1;
      q_o    <= '1;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// File: hw/isp_port.sv
// Purpose: Two-wire serial port, slave engine and firmware master pins
// Assumes: Wishbone classic slave, 8-bit registers in the low lane
// Notes:   Pins are open drain; outputs only ever pull low
`timescale 1ns/1ps
`include "isp_map.svh"
module isp_port #(
  parameter logic [3:0] MODE_7B    = 4'h6,
  parameter logic [3:0] MODE_10B   = 4'h7,
  parameter logic [3:0] MODE_7B_SP = 4'hE,
  parameter logic [3:0] MODE_10B_SP= 4'hF
) (
  input  wire logic        clk_i,    // System clock
  input  wire logic        rst_i,    // Sync reset, active high
  input  wire logic        wb_cyc_i, // Bus cycle
  input  wire logic        wb_stb_i, // Bus strobe
  input  wire logic        wb_we_i,  // Write enable
  input  wire logic [9:0]  wb_adr_i, // Byte address
  input  wire logic [3:0]  wb_sel_i, // Byte lanes
  input  wire logic [31:0] wb_dat_i, // Write data
  output logic      [31:0] wb_dat_o, // Read data
  output logic             wb_ack_o, // Acknowledge
  input  wire logic        scl_i,    // Clock pin level
  input  wire logic        sda_i,    // Data pin level
  output logic             scl_o,    // Clock pin drive value
  output logic             scl_oe_o, // Clock pin pulled low
  output logic             sda_o,    // Data pin drive value
  output logic             sda_oe_o, // Data pin pulled low
  output logic             irq_o     // Serial event interrupt
);
  import isp_pkg::*;

  // ==========================================================
  // Bus decode
  logic       req;
  logic [7:0] idx;
  logic       wr_int, wr_flg, wr_buf, wr_ctl, wr_dir;
  logic       wr_enb, wr_adr, wr_sta, rd_buf;
  logic [7:0] wdat;
  logic [7:0] rdata;

  assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx    = wb_adr_i[9:2];
  assign wdat   = wb_dat_i[7:0];
  assign wr_int = req & wb_we_i & wb_sel_i[0]
                  & (idx == `ISP_IDX_INT_CONTROL);
  assign wr_flg = req & wb_we_i & wb_sel_i[0]
                  & (idx == `ISP_IDX_FLAGS_ONE);
  assign wr_buf = req & wb_we_i & wb_sel_i[0]
                  & (idx == `ISP_IDX_DATA_BUFFER);
  assign wr_ctl = req & wb_we_i & wb_sel_i[0]
                  & (idx == `ISP_IDX_SERIAL_CONTROL);
  assign wr_dir = req & wb_we_i & wb_sel_i[0]
                  & (idx == `ISP_IDX_PORT_C_DIR);
  assign wr_enb = req & wb_we_i & wb_sel_i[0]
                  & (idx == `ISP_IDX_ENABLES_ONE);
  assign wr_adr = req & wb_we_i & wb_sel_i[0]
                  & (idx == `ISP_IDX_SLAVE_ADDRESS);
  assign wr_sta = req & wb_we_i & wb_sel_i[0]
                  & (idx == `ISP_IDX_SERIAL_STATUS);
  assign rd_buf = req & ~wb_we_i & (idx == `ISP_IDX_DATA_BUFFER);

  // ==========================================================
  // Registers
  logic [7:0] int_r, flg_r, enb_r, buf_r, ctl_r, dir_r, adr_r;
  logic [1:0] phs_r;
  logic       da_r, stop_r, start_r, rw_r, upd_r, full_r;
  logic       on;
  logic [3:0] mode;

  assign on   = ctl_r[`ISP_B_PORT_ON];
  assign mode = ctl_r[3:0];

  // ==========================================================
  // Pin synchroniser and condition detect
  logic [1:0] pin_s;
  logic [1:0] pin_d;
  logic       scl_rise, scl_fall, start_det, stop_det;

  isp_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({scl_i, sda_i}),
    .q_o   (pin_s)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_d <= 2'h3;
    end else begin
      pin_d <= pin_s;
    end
  end

  assign scl_rise  = pin_s[1] & ~pin_d[1];
  assign scl_fall  = ~pin_s[1] & pin_d[1];
  assign start_det = pin_s[1] & pin_d[1] & pin_d[0] & ~pin_s[0];
  assign stop_det  = pin_s[1] & pin_d[1] & ~pin_d[0] & pin_s[0];

  // ==========================================================
  // Mode decode
  logic m7, m10, sp_mode, cond_ev;

  assign m7  = (mode == MODE_7B) | (mode == MODE_7B_SP);
  assign m10 = (mode == MODE_10B) | (mode == MODE_10B_SP);
  // master idle mode also reports bus conditions
  assign sp_mode = (mode == MODE_7B_SP) | (mode == MODE_10B_SP)
                   | (mode == `ISP_MODE_MASTER_IDLE);
  assign cond_ev = on & sp_mode & (start_det | stop_det);

  // ==========================================================
  // Slave engine
  isp_state_e st_r;
  isp_phase_e ph_r;
  logic [7:0] sr_r;
  logic [3:0] cnt_r;
  logic       ack_r, xmit_r, prior_r, hold_upd_r, txf_r, nack_r;
  logic       ev_pls_r, ld_pls_r, ov_pls_r, upd_pls_r;
  logic       acc, hit7, hit10, tx_hold;

  // Overflow is judged on the state before the byte
  assign acc   = ~full_r & ~ctl_r[`ISP_B_OVERFLOW];
  // upper seven shift bits against the address
  assign hit7  = (sr_r[7:1] == adr_r[7:1]);
  // ten-bit tag plus the two top address bits
  assign hit10 = (sr_r[7:3] == `ISP_TEN_BIT_TAG)
                 & (sr_r[2:1] == adr_r[2:1]);
  assign tx_hold = scl_fall & xmit_r
                   & ((st_r == S_ACK) | ((st_r == S_TACK) & ~nack_r));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r       <= S_WAIT;
      ph_r       <= PH_A1;
      sr_r       <= 8'h00;
      cnt_r      <= 4'h0;
      ack_r      <= 1'b0;
      xmit_r     <= 1'b0;
      prior_r    <= 1'b0;
      hold_upd_r <= 1'b0;
      txf_r      <= 1'b0;
      nack_r     <= 1'b0;
      rw_r       <= 1'b0;
      da_r       <= 1'b0;
      ev_pls_r   <= 1'b0;
      ld_pls_r   <= 1'b0;
      ov_pls_r   <= 1'b0;
      upd_pls_r  <= 1'b0;
    end else begin
      ev_pls_r  <= 1'b0;
      ld_pls_r  <= 1'b0;
      ov_pls_r  <= 1'b0;
      upd_pls_r <= 1'b0;
      if (!on || stop_det) begin
        st_r   <= S_WAIT;
        ack_r  <= 1'b0;
        xmit_r <= 1'b0;
      end else if (start_det) begin
        // slave listens whatever the master side does
        st_r   <= S_RXB;
        ph_r   <= PH_A1;
        cnt_r  <= 4'h0;
        ack_r  <= 1'b0;
        xmit_r <= 1'b0;
      end else begin
        case (st_r)
          S_RXB: begin
            if (scl_rise) begin
              sr_r  <= {sr_r[6:0], pin_s[0]};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == `ISP_BITS_PER_BYTE) begin
              st_r       <= S_WAIT;
              hold_upd_r <= 1'b0;
              if (ph_r == PH_A2) begin
                ev_pls_r  <= 1'b1;
                upd_pls_r <= 1'b1;
                if (sr_r == adr_r) begin
                  prior_r    <= 1'b1;
                  ld_pls_r   <= 1'b1;
                  ack_r      <= 1'b1;
                  hold_upd_r <= 1'b1;
                  ph_r       <= PH_DAT;
                  st_r       <= S_ACK;
                end
              end else if (ph_r == PH_DAT) begin
                ev_pls_r <= 1'b1;
                ld_pls_r <= acc;
                ov_pls_r <= ~acc;
                ack_r    <= acc;
                da_r     <= 1'b1;
                st_r     <= S_ACK;
              end else if (m7 && hit7) begin
                ev_pls_r <= 1'b1;
                rw_r     <= sr_r[0];
                da_r     <= 1'b0;
                xmit_r   <= sr_r[0];
                ld_pls_r <= sr_r[0] | acc;
                ov_pls_r <= ~sr_r[0] & ~acc;
                ack_r    <= sr_r[0] | acc;
                ph_r     <= PH_DAT;
                st_r     <= S_ACK;
              end else if (m10 && hit10 && !sr_r[0]) begin
                prior_r    <= 1'b0;
                ev_pls_r   <= 1'b1;
                rw_r       <= 1'b0;
                da_r       <= 1'b0;
                ld_pls_r   <= acc;
                ov_pls_r   <= ~acc;
                ack_r      <= acc;
                upd_pls_r  <= acc;
                hold_upd_r <= acc;
                ph_r       <= PH_A2;
                st_r       <= S_ACK;
              end else if (m10 && hit10 && prior_r) begin
                // read after an earlier full match
                ev_pls_r <= 1'b1;
                rw_r     <= 1'b1;
                da_r     <= 1'b0;
                ld_pls_r <= 1'b1;
                ack_r    <= 1'b1;
                xmit_r   <= 1'b1;
                ph_r     <= PH_DAT;
                st_r     <= S_ACK;
              end else begin
                // any other byte forgets the match
                prior_r <= 1'b0;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              ack_r <= 1'b0;
              cnt_r <= 4'h0;
              if (xmit_r || hold_upd_r) begin
                st_r  <= S_HOLD;
                txf_r <= 1'b0;
              end else begin
                st_r <= S_RXB;
              end
            end
          end
          S_HOLD: begin
            if (xmit_r && wr_buf) begin
              sr_r  <= wdat;
              txf_r <= 1'b1;
            end
            // stretch while empty and not released
            if (xmit_r && (txf_r || ctl_r[`ISP_B_RELEASE])) begin
              st_r  <= S_TXB;
              cnt_r <= 4'h0;
            end else if (!xmit_r && !upd_r) begin
              // held until the address is rewritten
              st_r  <= S_RXB;
              cnt_r <= 4'h0;
            end
          end
          S_TXB: begin
            if (scl_fall) begin
              sr_r  <= {sr_r[6:0], 1'b1};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == `ISP_BITS_PER_BYTE - 4'h1) begin
                st_r <= S_TACK;
              end
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              nack_r <= pin_s[0];
            end else if (scl_fall) begin
              ev_pls_r <= 1'b1;
              if (nack_r) begin
                st_r   <= S_WAIT;
                xmit_r <= 1'b0;
              end else begin
                st_r  <= S_HOLD;
                txf_r <= 1'b0;
              end
            end
          end
          default: st_r <= S_WAIT;
        endcase
      end
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_r <= `ISP_RST_ZERO;
      enb_r <= `ISP_RST_ZERO;
      dir_r <= `ISP_RST_PORT_C_DIR;
      adr_r <= `ISP_RST_ZERO;
      phs_r <= 2'h0;
    end else begin
      if (wr_int) int_r <= wdat;
      if (wr_enb) enb_r <= wdat;
      if (wr_dir) dir_r <= wdat;
      if (wr_adr) adr_r <= wdat;
      if (wr_sta) phs_r <= wdat[7:6];
    end
  end

  // Hardware sets win over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flg_r <= `ISP_RST_ZERO;
    end else begin
      if (wr_flg) flg_r <= wdat;
      // event on byte or bus condition
      if (ev_pls_r || cond_ev) flg_r[`ISP_B_EVENT] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= `ISP_RST_ZERO;
    end else begin
      if (wr_ctl) ctl_r <= wdat;
      // overflow stays until software clears it
      if (ov_pls_r) ctl_r[`ISP_B_OVERFLOW] <= 1'b1;
      if (wr_buf && st_r == S_TXB) ctl_r[`ISP_B_COLLISION] <= 1'b1;
      if (tx_hold) ctl_r[`ISP_B_RELEASE] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_r  <= `ISP_RST_ZERO;
      full_r <= 1'b0;
      upd_r  <= 1'b0;
    end else begin
      if (wr_buf) buf_r <= wdat;
      if (ld_pls_r) buf_r <= sr_r;
      if (rd_buf) full_r <= 1'b0;
      if (ld_pls_r) full_r <= 1'b1;
      if (wr_adr) upd_r <= 1'b0;
      if (upd_pls_r) upd_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !on) begin
      start_r <= 1'b0;
      stop_r  <= 1'b0;
    end else if (start_det) begin
      start_r <= 1'b1;
      stop_r  <= 1'b0;
    end else if (stop_det) begin
      start_r <= 1'b0;
      stop_r  <= 1'b1;
    end
  end

  // ==========================================================
  // Read mux and bus answer
  always_comb begin
    case (idx)
      `ISP_IDX_INT_CONTROL:    rdata = int_r;
      `ISP_IDX_FLAGS_ONE:      rdata = {flg_r[7:6], 2'h0, flg_r[3:0]};
      `ISP_IDX_DATA_BUFFER:    rdata = buf_r;
      `ISP_IDX_SERIAL_CONTROL: rdata = ctl_r;
      `ISP_IDX_PORT_C_DIR:     rdata = {2'h0, dir_r[5:0]};
      `ISP_IDX_ENABLES_ONE:    rdata = {enb_r[7:6], 2'h0, enb_r[3:0]};
      `ISP_IDX_SLAVE_ADDRESS:  rdata = adr_r;
      `ISP_IDX_SERIAL_STATUS:  rdata = {phs_r, da_r, stop_r, start_r,
                                        rw_r, upd_r, full_r};
      default:                 rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? {24'h00_0000, rdata} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Pins and interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      irq_o    <= 1'b0;
    end else begin
      // only low levels, a one is a released pin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_o <= ~dir_r[`ISP_B_SCL_DIR] | (st_r == S_HOLD);
      sda_oe_o <= ~dir_r[`ISP_B_SDA_DIR] | ((st_r == S_ACK) & ack_r)
                  | ((st_r == S_TXB) & ~sr_r[7]);
      // stop or byte event reaches the interrupt line
      irq_o    <= int_r[`ISP_B_GLOBAL_GATE] & int_r[`ISP_B_PERIPH_GATE]
                  & enb_r[`ISP_B_EVENT] & flg_r[`ISP_B_EVENT];
    end
  end

  // ==========================================================
  // Checks
  property p_off_clear;
    @(posedge clk_i) disable iff (rst_i)
    !on |=> (!start_r && !stop_r);
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("bits not cleared");

  property p_start_bit;
    @(posedge clk_i) disable iff (rst_i)
    (on && start_det) |=> (start_r && !stop_r);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit");

  property p_cond_event;
    @(posedge clk_i) disable iff (rst_i)
    cond_ev |=> flg_r[`ISP_B_EVENT];
  endproperty
  a_cond_event: assert property (p_cond_event) else $error("no event");

  property p_low_drive;
    @(posedge clk_i) disable iff (rst_i)
    !dir_r[`ISP_B_SDA_DIR] |=> (sda_oe_o && !sda_o);
  endproperty
  a_low_drive: assert property (p_low_drive) else $error("sda drive");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    (on && stop_det && sp_mode && int_r[`ISP_B_GLOBAL_GATE]
     && int_r[`ISP_B_PERIPH_GATE] && enb_r[`ISP_B_EVENT]) |=> ##1 irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("stop irq missing");

  property p_overflow;
    @(posedge clk_i) disable iff (rst_i)
    (on && !start_det && !stop_det && st_r == S_RXB && scl_fall
     && cnt_r == `ISP_BITS_PER_BYTE && ph_r == PH_DAT && !acc)
    |=> !ack_r ##1 ctl_r[`ISP_B_OVERFLOW];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow");

  property p_stretch;
    @(posedge clk_i) disable iff (rst_i)
    (st_r == S_HOLD && xmit_r && !txf_r && !ctl_r[`ISP_B_RELEASE])
    |=> scl_oe_o;
  endproperty
  a_stretch: assert property (p_stretch) else $error("no stretch");

  property p_read_clear;
    @(posedge clk_i) disable iff (rst_i)
    (rd_buf && !ld_pls_r) |=> !full_r;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("full kept");

  property p_nack_end;
    @(posedge clk_i) disable iff (rst_i)
    (on && !start_det && !stop_det && st_r == S_TACK && scl_fall
     && nack_r) |=> (st_r == S_WAIT && !xmit_r);
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("nack end");
endmodule

// File: sim/isp_bus_master.sv
// Purpose: Behavioural two-wire bus master facing the serial port pins
// Assumes: Open-drain wires with pull-ups, 320 ns bit period
// Notes:   Honours clock stretching; the bench watchdog bounds any wait
`timescale 1ns/1ps
module isp_bus_master (
  input  wire logic scl_oe_i, // Device pulls clock low
  input  wire logic sda_oe_i, // Device pulls data low
  output logic      scl_o,    // Resolved clock wire
  output logic      sda_o     // Resolved data wire
);
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  logic lost  = 1'b0;
  // Released lines float to the pull-up level
  assign scl_o = m_scl & ~scl_oe_i;
  assign sda_o = m_sda & ~sda_oe_i;
  // ==========================================================
  // Bit and frame tasks
  task automatic pulse(output logic b);
    #80 m_scl = 1'b1;
    wait (scl_o === 1'b1);
    // The slave may grab the clock in the very step it is let go
    #1;
    wait (scl_o === 1'b1);
    #79 b = sda_o;
    #80 m_scl = 1'b0;
    #80;
  endtask
  task automatic start();
    m_sda = 1'b1;
    #80 m_scl = 1'b1;
    #160 m_sda = 1'b0;
    #160 m_scl = 1'b0;
  endtask
  task automatic stop();
    m_sda = 1'b0;
    #80 m_scl = 1'b1;
    #160 m_sda = 1'b1;
    #160;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      m_sda = d[i] | lost;
      pulse(b);
      // a high read back low loses the bus; let data go
      if (d[i] && !b) lost = 1'b1;
    end
    m_sda = 1'b1;
    pulse(b);
    ack = ~b;
  endtask
  task automatic recv(input logic give_ack, output logic [7:0] d);
    logic b;
    m_sda = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(b);
      d[i] = b;
    end
    m_sda = ~give_ack;
    pulse(b);
    m_sda = 1'b1;
  endtask
endmodule

// File: sim/isp_port_test.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Bus master model on the pins, Wishbone classic register access
// Notes:   Random slave address and data from a fixed seed
`timescale 1ns/1ps
`include "isp_map.svh"
module isp_port_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, scl, sda, scl_oe, sda_oe, scl_d, sda_d, irq;
  int fails = 0;
  int num_checks = 0;
  logic [6:0] a;
  logic [7:0] d0, d1, d2, q, rx;
  logic ak;
  always #20 clk_i = ~clk_i;
  isp_port i_isp_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl),
    .sda_i(sda), .scl_o(scl_d), .scl_oe_o(scl_oe), .sda_o(sda_d),
    .sda_oe_o(sda_oe), .irq_o(irq));
  isp_bus_master i_isp_bus_master (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .scl_o(scl), .sda_o(sda));
  // ==========================================================
  // Helpers
  function automatic logic [7:0] st_exp(input logic s, input logic p);
    return {3'h0, p, s, 3'h0};
  endfunction
  function automatic logic [7:0] b8(input logic x);
    return {7'h00, x};
  endfunction
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, idx, d, r);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] r);
    wb(1'b0, idx, 8'h00, r);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    #2000000;
    fails++;
    wrap_up();
  end
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(11255));
    a = 7'h10 + 7'($urandom % 96);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ISP_IDX_PORT_C_DIR, q);
    chk("dir reset", q, `ISP_RST_PORT_C_DIR);
    rd(`ISP_IDX_SERIAL_CONTROL, q);
    chk("control reset", q, `ISP_RST_ZERO);
    rd(8'h20, q);
    chk("unmapped", q, 8'h00);
    $display("test registers done");
    wr(`ISP_IDX_SERIAL_CONTROL, 8'h2B);
    rd(`ISP_IDX_SERIAL_STATUS, q);
    chk("bus free", q & 8'h18, st_exp(0, 0));
    wr(`ISP_IDX_PORT_C_DIR, 8'h2F);
    repeat (4) @(posedge clk_i);
    chk("sda pulled", b8(sda_oe), 8'h01);
    chk("sda value", b8(sda_d), 8'h00);
    rd(`ISP_IDX_SERIAL_STATUS, q);
    chk("start bit", q & 8'h18, st_exp(1, 0));
    rd(`ISP_IDX_FLAGS_ONE, q);
    chk("start event", q & 8'h08, 8'h08);
    wr(`ISP_IDX_PORT_C_DIR, 8'h3F);
    repeat (4) @(posedge clk_i);
    rd(`ISP_IDX_SERIAL_STATUS, q);
    chk("stop bit", q & 8'h18, st_exp(0, 1));
    $display("test master pins done");
    wr(`ISP_IDX_SERIAL_CONTROL, 8'h2E);
    wr(`ISP_IDX_SLAVE_ADDRESS, {a, 1'b0});
    wr(`ISP_IDX_INT_CONTROL, 8'hC0);
    wr(`ISP_IDX_ENABLES_ONE, 8'h08);
    i_isp_bus_master.start();
    wr(`ISP_IDX_FLAGS_ONE, 8'h00);
    i_isp_bus_master.send({a, 1'b0}, ak);
    chk("addr ack", b8(ak), 8'h01);
    rd(`ISP_IDX_FLAGS_ONE, q);
    chk("addr event", q & 8'h08, 8'h08);
    rd(`ISP_IDX_DATA_BUFFER, q);
    chk("addr byte", q, {a, 1'b0});
    i_isp_bus_master.send(d0, ak);
    chk("data ack", b8(ak), 8'h01);
    i_isp_bus_master.send(d1, ak);
    chk("full nack", b8(ak), 8'h00);
    rd(`ISP_IDX_SERIAL_CONTROL, q);
    chk("overflow", q & 8'h40, 8'h40);
    rd(`ISP_IDX_DATA_BUFFER, q);
    chk("kept byte", q, d0);
    rd(`ISP_IDX_SERIAL_STATUS, q);
    chk("full clear", q & 8'h01, 8'h00);
    rd(`ISP_IDX_SERIAL_CONTROL, q);
    chk("overflow kept", q & 8'h40, 8'h40);
    wr(`ISP_IDX_FLAGS_ONE, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("irq low", b8(irq), 8'h00);
    i_isp_bus_master.stop();
    repeat (6) @(posedge clk_i);
    chk("irq at stop", b8(irq), 8'h01);
    wr(`ISP_IDX_SERIAL_CONTROL, 8'h0E);
    rd(`ISP_IDX_SERIAL_STATUS, q);
    chk("disable clears", q & 8'h18, st_exp(0, 0));
    $display("test receive done");
    wr(`ISP_IDX_SERIAL_CONTROL, 8'h2E);
    i_isp_bus_master.start();
    i_isp_bus_master.send({a, 1'b1}, ak);
    chk("read addr ack", b8(ak), 8'h01);
    fork
      i_isp_bus_master.recv(1'b0, rx);
      begin
        repeat (30) @(posedge clk_i);
        chk("stretch", b8(scl_oe), 8'h01);
        wr(`ISP_IDX_DATA_BUFFER, d2);
      end
    join
    chk("sent byte", rx, d2);
    repeat (10) @(posedge clk_i);
    chk("released", b8(scl_oe), 8'h00);
    i_isp_bus_master.send(d0, ak);
    chk("not addressed", b8(ak), 8'h00);
    i_isp_bus_master.stop();
    $display("test transmit done");
    wr(`ISP_IDX_SERIAL_CONTROL, 8'h2F);
    wr(`ISP_IDX_SLAVE_ADDRESS, {5'h1E, a[1:0], 1'b0});
    rd(`ISP_IDX_DATA_BUFFER, q);
    i_isp_bus_master.start();
    i_isp_bus_master.send({5'h1E, a[1:0], 1'b0}, ak);
    chk("high ack", b8(ak), 8'h01);
    rd(`ISP_IDX_SERIAL_STATUS, q);
    chk("update set", q & 8'h02, 8'h02);
    wr(`ISP_IDX_SLAVE_ADDRESS, {a, 1'b0});
    rd(`ISP_IDX_SERIAL_STATUS, q);
    chk("update clear", q & 8'h02, 8'h00);
    rd(`ISP_IDX_DATA_BUFFER, q);
    i_isp_bus_master.send({a, 1'b0}, ak);
    chk("low ack", b8(ak), 8'h01);
    rd(`ISP_IDX_SERIAL_STATUS, q);
    chk("low update", q & 8'h03, 8'h03);
    wr(`ISP_IDX_SLAVE_ADDRESS, {5'h1E, a[1:0], 1'b0});
    rd(`ISP_IDX_DATA_BUFFER, q);
    chk("low byte", q, {a, 1'b0});
    i_isp_bus_master.send(d1, ak);
    chk("ten bit data", b8(ak), 8'h01);
    i_isp_bus_master.stop();
    chk("arbitration", b8(i_isp_bus_master.lost), 8'h00);
    $display("test ten bit done");
    wrap_up();
  end
endmodule
